// *** verilog/dcc_pkg.sv ***
package dcc_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 24;

  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_RESERVED_A = 8'h34;
  localparam logic [7:0] IDX_RESERVED_B = 8'h35;
  localparam logic [7:0] IDX_PIN_CTRL = 8'h36;
  localparam logic [7:0] IDX_RESERVED_C_LO = 8'h37;
  localparam logic [7:0] IDX_RESERVED_C_HI = 8'h3B;
  localparam logic [7:0] IDX_BLOCK_SEL = 8'h3C;
  localparam logic [7:0] IDX_RESERVED_D_LO = 8'h3D;
  localparam logic [7:0] IDX_RESERVED_D_HI = 8'h3E;
  localparam logic [7:0] IDX_PATH_SETUP = 8'h3F;
  localparam logic [7:0] IDX_MUTE_LINK = 8'h40;
  localparam logic [7:0] IDX_LEFT_VOL = 8'h41;
  localparam logic [7:0] IDX_RIGHT_VOL = 8'h42;
  localparam logic [7:0] IDX_COMP_CTRL = 8'h60;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PIN_LEVEL_BIT = 0;
  localparam int PIN_MODE_LO = 1;
  localparam int PATH_LPWR_BIT = 7;
  localparam int PATH_RPWR_BIT = 6;
  localparam int PATH_LSRC_LO = 4;
  localparam int PATH_RSRC_LO = 2;
  localparam int PATH_STEP_LO = 0;
  localparam int VOLC_LMUTE_BIT = 3;
  localparam int VOLC_RMUTE_BIT = 2;
  localparam int VOLC_LINK_LO = 0;
  localparam int COMP_EN_BIT = 0;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] PIN_OFF = 2'h0;
  localparam logic [1:0] PIN_INTERFACE = 2'h1;
  localparam logic [1:0] PIN_GENERAL_PURPOSE_INPUT = 2'h2;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_OWN = 2'h1;
  localparam logic [1:0] SRC_OTHER = 2'h2;
  localparam logic [1:0] SRC_AVERAGE = 2'h3;
  localparam logic [1:0] STEP_EVERY = 2'h0;
  localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
  localparam logic [1:0] STEP_OFF = 2'h2;
  localparam logic [1:0] LINK_LEFT_FROM_RIGHT = 2'h1;
  localparam logic [1:0] LINK_RIGHT_FROM_LEFT = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_PIN_MODE = 2'h1;
  localparam logic [4:0] RST_BLOCK = 5'h01;
  localparam logic [1:0] RST_LSRC = 2'h1;
  localparam logic [1:0] RST_RSRC = 2'h1;
  localparam logic [1:0] RST_STEP = 2'h0;
  localparam logic RST_MUTE = 1'b1;
  localparam logic [1:0] RST_LINK = 2'h0;
  localparam logic [7:0] RST_VOL = 8'h00;

  // ----------------------------------------------------------------
  // bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** verilog/dcc_vol_step.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcc_vol_step (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sample_tick,
  input wire logic [1:0] rate,
  input wire logic [7:0] target,
  output logic [7:0] current
);
  logic half;
  logic move;

  // ----------------------------------------------------------------
  // pacing of soft steps
  // ----------------------------------------------------------------
  // every sample tick toggles half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half <= 1'b0;
    end else if (sample_tick) begin
      half <= ~half;
    end
  end

  assign move = sample_tick &&
                (rate == dcc_pkg::STEP_EVERY ||
                 (rate == dcc_pkg::STEP_EVERY_TWO && half));

  // ----------------------------------------------------------------
  // applied volume code
  // ----------------------------------------------------------------
  // reserved rate 11 behaves as stepping disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current <= dcc_pkg::RST_VOL;
    end else if (rate == dcc_pkg::STEP_OFF ||
                 rate == 2'h3) begin
      current <= target;
    end else if (move && current != target) begin
      if ($signed(current) < $signed(target)) begin
        current <= current + 8'h01;
      end else begin
        current <= current - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_step_off_jump: assert property (@(posedge aclk)
    disable iff (!aresetn)
    rate == dcc_pkg::STEP_OFF |=> current == $past(target))
    else $error("volume did not jump with stepping off");
  a_step_single: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (rate == dcc_pkg::STEP_EVERY && sample_tick && current != target)
    |=> (current == $past(current) + 8'h01 ||
         current == $past(current) - 8'h01))
    else $error("soft step did not move by one code");
  a_step_hold: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (rate == dcc_pkg::STEP_EVERY && !sample_tick)
    |=> current == $past(current))
    else $error("volume moved without a sample tick");
  c_step_two: cover property (@(posedge aclk) disable iff (!aresetn)
    rate == dcc_pkg::STEP_EVERY_TWO && move);
endmodule
`default_nettype wire

// *** verilog/dcc_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - pin mode 00 powers the input off, 01 feeds the interface, 10 is a general input, bit 0 reads the live level.
// - a five-bit field picks processing block 1 to 25, resetting to block 1.
// - path bit 7 powers the left channel up, reset leaves it down.
// - path bit 6 powers the right channel up, reset leaves it down.
// - the left source is off, left, right or the average, resetting to left.
// - the right source is off, right, left or the average, resetting to right.
// - soft step moves one code per sample, per two samples, or not at all.
// - mute bit 3 silences the left channel and resets set.
// - mute bit 2 silences the right channel and resets set.
// - link 01 gives left the right volume, 10 gives right the left, else independent.
// - with compression on the volumes stay independent and software leaves link at 00.
// - the left volume is a signed half-dB code resetting to 0 dB.
// - the right volume uses the same code as the left.
module dcc_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_data_pin,
  output logic serial_data_to_interface,
  output logic general_purpose_input,
  output logic [4:0] block_select,
  output logic left_power_up,
  output logic right_power_up,
  input wire logic sample_strobe,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  output logic [23:0] left_out,
  output logic [23:0] right_out,
  output logic [7:0] left_volume,
  output logic [7:0] right_volume
);
  logic aw_held, w_held, aw_ok, w_lane0;
  logic [7:0] aw_idx, w_byte, rd_value;
  logic wr_fire;
  logic pin_meta, pin_sync;
  logic [1:0] pin_mode, left_src, right_src, step_rate, vol_link;
  logic left_mute, right_mute, comp_enable;
  logic [7:0] left_vol_code, right_vol_code, left_target, right_target;
  logic [23:0] left_route, right_route;

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] idx_of(input logic [11:0] addr);
    idx_of = addr[9:2];
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    logic [7:0] i;
    i = addr[9:2];
    mapped = addr[11:10] == 2'h0 &&
             ((i >= dcc_pkg::IDX_RESERVED_A &&
               i <= dcc_pkg::IDX_RIGHT_VOL) ||
              i == dcc_pkg::IDX_COMP_CTRL);
  endfunction

  // source selection shared by both channels
  function automatic logic [23:0] route(input logic [1:0] sel,
                                        input logic [23:0] own,
                                        input logic [23:0] other);
    logic [24:0] sum;
    sum = {own[23], own} + {other[23], other};
    unique case (sel)
      dcc_pkg::SRC_OFF: route = 24'h000000;
      dcc_pkg::SRC_OWN: route = own;
      dcc_pkg::SRC_OTHER: route = other;
      dcc_pkg::SRC_AVERAGE: route = sum[24:1];
    endcase
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // address and data are caught in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
      aw_ok <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx <= idx_of(s_axi_awaddr);
      aw_ok <= mapped(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_byte <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // response once both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= aw_ok ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // reserved indices are not stored, writes there are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_mode <= dcc_pkg::RST_PIN_MODE;
      block_select <= dcc_pkg::RST_BLOCK;
      left_power_up <= 1'b0;
      right_power_up <= 1'b0;
      left_src <= dcc_pkg::RST_LSRC;
      right_src <= dcc_pkg::RST_RSRC;
      step_rate <= dcc_pkg::RST_STEP;
      left_mute <= dcc_pkg::RST_MUTE;
      right_mute <= dcc_pkg::RST_MUTE;
      vol_link <= dcc_pkg::RST_LINK;
      left_vol_code <= dcc_pkg::RST_VOL;
      right_vol_code <= dcc_pkg::RST_VOL;
      comp_enable <= 1'b0;
    end else if (wr_fire && w_lane0 && aw_ok) begin
      unique case (aw_idx)
        dcc_pkg::IDX_PIN_CTRL: begin
          pin_mode <= w_byte[dcc_pkg::PIN_MODE_LO +: 2];
        end
        dcc_pkg::IDX_BLOCK_SEL: begin
          block_select <= w_byte[4:0];
        end
        dcc_pkg::IDX_PATH_SETUP: begin
          left_power_up <= w_byte[dcc_pkg::PATH_LPWR_BIT];
          right_power_up <= w_byte[dcc_pkg::PATH_RPWR_BIT];
          left_src <= w_byte[dcc_pkg::PATH_LSRC_LO +: 2];
          right_src <= w_byte[dcc_pkg::PATH_RSRC_LO +: 2];
          step_rate <= w_byte[dcc_pkg::PATH_STEP_LO +: 2];
        end
        dcc_pkg::IDX_MUTE_LINK: begin
          left_mute <= w_byte[dcc_pkg::VOLC_LMUTE_BIT];
          right_mute <= w_byte[dcc_pkg::VOLC_RMUTE_BIT];
          vol_link <= w_byte[dcc_pkg::VOLC_LINK_LO +: 2];
        end
        dcc_pkg::IDX_LEFT_VOL: left_vol_code <= w_byte;
        dcc_pkg::IDX_RIGHT_VOL: right_vol_code <= w_byte;
        dcc_pkg::IDX_COMP_CTRL: comp_enable <= w_byte[dcc_pkg::COMP_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // readback value of one index, reserved bits as zero
  always_comb begin
    rd_value = 8'h00;
    unique case (idx_of(s_axi_araddr))
      dcc_pkg::IDX_PIN_CTRL: begin
        rd_value = {5'h00, pin_mode,
                    pin_sync && pin_mode != dcc_pkg::PIN_OFF};
      end
      dcc_pkg::IDX_BLOCK_SEL: rd_value = {3'h0, block_select};
      dcc_pkg::IDX_PATH_SETUP: begin
        rd_value = {left_power_up, right_power_up, left_src, right_src,
                    step_rate};
      end
      dcc_pkg::IDX_MUTE_LINK: begin
        rd_value = {4'h0, left_mute, right_mute, vol_link};
      end
      dcc_pkg::IDX_LEFT_VOL: rd_value = left_vol_code;
      dcc_pkg::IDX_RIGHT_VOL: rd_value = right_vol_code;
      dcc_pkg::IDX_COMP_CTRL: rd_value = {7'h00, comp_enable};
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dcc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, mapped(s_axi_araddr) ? rd_value : 8'h00};
      s_axi_rresp <= mapped(s_axi_araddr) ? dcc_pkg::RESP_OKAY :
                     dcc_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // serial input pin
  // ----------------------------------------------------------------
  // two-stage synchroniser, pin_meta feeds pin_sync only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= serial_data_pin;
      pin_sync <= pin_meta;
    end
  end

  // pin level steered by mode, off and reserved give zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_data_to_interface <= 1'b0;
      general_purpose_input <= 1'b0;
    end else begin
      serial_data_to_interface <= pin_sync &&
                                  pin_mode == dcc_pkg::PIN_INTERFACE;
      general_purpose_input <= pin_sync &&
                               pin_mode == dcc_pkg::PIN_GENERAL_PURPOSE_INPUT;
    end
  end

  // ----------------------------------------------------------------
  // volume targets and soft stepping
  // ----------------------------------------------------------------
  // compression forces independent volumes
  assign left_target = (!comp_enable &&
                        vol_link == dcc_pkg::LINK_LEFT_FROM_RIGHT) ?
                       right_vol_code : left_vol_code;
  assign right_target = (!comp_enable &&
                         vol_link == dcc_pkg::LINK_RIGHT_FROM_LEFT) ?
                        left_vol_code : right_vol_code;

  dcc_vol_step u_left_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_tick(sample_strobe),
    .rate(step_rate),
    .target(left_target),
    .current(left_volume)
  );

  dcc_vol_step u_right_step (
    .aclk(aclk),
    .aresetn(aresetn),
    .sample_tick(sample_strobe),
    .rate(step_rate),
    .target(right_target),
    .current(right_volume)
  );

  // ----------------------------------------------------------------
  // channel data paths
  // ----------------------------------------------------------------
  assign left_route = route(left_src, left_sample, right_sample);
  assign right_route = route(right_src, right_sample, left_sample);

  // output updates per sample, silent when muted or powered down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_out <= 24'h000000;
      right_out <= 24'h000000;
    end else if (sample_strobe) begin
      left_out <= (left_power_up && !left_mute) ?
                  left_route : 24'h000000;
      right_out <= (right_power_up && !right_mute) ?
                   right_route : 24'h000000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_values: assert property (@(posedge aclk)
    $past(!aresetn) && aresetn |-> pin_mode == 2'h1 &&
    block_select == 5'h01 && left_mute && right_mute && !left_power_up &&
    !right_power_up)
    else $error("control fields wrong after reset");
  a_left_muted: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sample_strobe && left_mute |=> left_out == 24'h000000)
    else $error("muted left channel produced data");
  a_right_down: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sample_strobe && !right_power_up |=> right_out == 24'h000000)
    else $error("powered-down right channel produced data");
  // sum checked on 25 bits so full-scale samples do not wrap
  a_left_average: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sample_strobe && left_power_up && !left_mute && left_src == 2'h3
    |=> $signed({left_out[23], left_out}) ==
        ($signed({$past(left_sample[23]), $past(left_sample)}) +
         $signed({$past(right_sample[23]), $past(right_sample)})) >>> 1)
    else $error("average path wrong");
  a_right_swap: assert property (@(posedge aclk)
    disable iff (!aresetn)
    sample_strobe && right_power_up && !right_mute && right_src == 2'h2
    |=> right_out == $past(left_sample))
    else $error("right path did not take left data");
  a_link_left: assert property (@(posedge aclk)
    disable iff (!aresetn)
    vol_link == 2'h1 && !comp_enable && step_rate == dcc_pkg::STEP_OFF
    |=> left_volume == $past(right_vol_code))
    else $error("left volume not linked to right");
  a_comp_indep: assert property (@(posedge aclk)
    disable iff (!aresetn)
    comp_enable && step_rate == dcc_pkg::STEP_OFF |=>
    left_volume == $past(left_vol_code) &&
    right_volume == $past(right_vol_code))
    else $error("volumes linked while compression on");
  a_gpi_follow: assert property (@(posedge aclk)
    disable iff (!aresetn)
    pin_mode == 2'h2 ##1 pin_mode == 2'h2 |-> general_purpose_input ==
    $past(pin_sync))
    else $error("general input does not follow the pin");
  a_pin_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    pin_mode == 2'h0 |=> !serial_data_to_interface)
    else $error("pin passed data while powered off");
  a_vol_write: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_fire && w_lane0 && aw_ok && aw_idx == 8'h41 |=> left_vol_code ==
    $past(w_byte))
    else $error("left volume write lost");
  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && s_axi_bresp == (aw_ok ? 2'h0 : 2'h3))
    else $error("write response missing or wrong");
  c_average: cover property (@(posedge aclk) disable iff (!aresetn)
    sample_strobe && left_src == 2'h3 && left_power_up && !left_mute);
  c_link: cover property (@(posedge aclk) disable iff (!aresetn)
    vol_link == 2'h2 && !comp_enable);
  c_decerr: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule
`default_nettype wire

// *** verification/dcc_regs_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module dcc_regs_tb_top;
  // ------------------------------------------------------------
  // stimulus and design
  // ------------------------------------------------------------
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, serial_data_to_interface, general_purpose_input;
  logic left_power_up, right_power_up, serial_data_pin = 0;
  logic sample_strobe = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [4:0] block_select;
  logic [23:0] left_sample = 0, right_sample = 0, left_out, right_out;
  logic [7:0] left_volume, right_volume;
  logic [31:0] rd;
  int error_cnt = 0, n_compared = 0, cyc = 0;
  dcc_regs i_dcc_regs (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serial_data_pin, .serial_data_to_interface,
    .general_purpose_input, .block_select, .left_power_up,
    .right_power_up, .sample_strobe, .left_sample, .right_sample,
    .left_out, .right_out, .left_volume, .right_volume);
  // clock and hang limit
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk("bresp", (idx == 8'h10) ? 3 : 0, s_axi_bresp);
  endtask
  task automatic rdc(logic [7:0] idx, logic [31:0] exp, logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
  endtask
  task automatic strobe(logic [23:0] l, logic [23:0] r);
    @(posedge aclk);
    sample_strobe <= 1;
    left_sample <= l;
    right_sample <= r;
    @(posedge aclk);
    sample_strobe <= 0;
    repeat (3) @(posedge aclk);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdc(8'h36, 32'h02, 0);
    rdc(8'h3C, 32'h01, 0);
    rdc(8'h3F, 32'h14, 0);
    rdc(8'h40, 32'h0C, 0);
    rdc(8'h41, 32'h00, 0);
    rdc(8'h35, 32'h00, 0);
    wr(8'h10, 8'h55);
    rdc(8'h10, 32'h00, 3);
    chk("lpwr", 0, left_power_up);
    chk("rpwr", 0, right_power_up);
    $display("reset test done");
  endtask
  task automatic t_block();
    wr(8'h3C, 8'h19);
    rdc(8'h3C, 32'h19, 0);
    chk("block", 5'h19, block_select);
    $display("block test done");
  endtask
  task automatic t_pin();
    wr(8'h36, 8'h04);
    serial_data_pin <= 1;
    repeat (5) @(posedge aclk);
    chk("gpi", 1, general_purpose_input);
    chk("din", 0, serial_data_to_interface);
    rdc(8'h36, 32'h05, 0);
    wr(8'h36, 8'h02);
    repeat (5) @(posedge aclk);
    chk("din", 1, serial_data_to_interface);
    chk("gpi", 0, general_purpose_input);
    wr(8'h36, 8'h00);
    rdc(8'h36, 32'h00, 0);
    $display("pin test done");
  endtask
  task automatic t_path();
    wr(8'h3F, 8'hFA);
    wr(8'h40, 8'h00);
    strobe(24'h7FFFFF, 24'h7FFFFD);
    chk("lpwr", 1, left_power_up);
    chk("rpwr", 1, right_power_up);
    chk("lout", 24'h7FFFFE, left_out);
    chk("rout", 24'h7FFFFF, right_out);
    wr(8'h40, 8'h08);
    strobe(24'h000010, 24'h000020);
    chk("lmute", 0, left_out);
    chk("rout", 24'h000010, right_out);
    $display("path test done");
  endtask
  task automatic t_vol();
    wr(8'h41, 8'h30);
    wr(8'h42, 8'h81);
    wr(8'h40, 8'h01);
    strobe(0, 0);
    chk("lvol", 8'h81, left_volume);
    wr(8'h60, 8'h01);
    strobe(0, 0);
    chk("lvol", 8'h30, left_volume);
    wr(8'h60, 8'h00);
    wr(8'h40, 8'h02);
    strobe(0, 0);
    chk("rvol", 8'h30, right_volume);
    wr(8'h40, 8'h00);
    wr(8'h3F, 8'hF8);
    wr(8'h41, 8'h2E);
    strobe(0, 0);
    chk("lstep", 8'h2F, left_volume);
    wr(8'h3F, 8'hF9);
    wr(8'h41, 8'h2C);
    strobe(0, 0);
    strobe(0, 0);
    chk("lstep2", 8'h2E, left_volume);
    $display("volume test done");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_block();
    t_pin();
    t_path();
    t_vol();
    close_out();
  end
endmodule
`default_nettype wire
